// File: src/psc_pkg.sv
`default_nettype none
package psc_pkg;
  // Extended setup word layout
  localparam int unsigned WORD_W = 16;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned VSD_MASK_BIT = 5;
  localparam int unsigned ISD_MASK_BIT = 6;
  localparam int unsigned TSD_MASK_BIT = 7;
  localparam int unsigned RST_MASK_C_BIT = 8;
  localparam int unsigned RST_MASK_B_BIT = 9;
  localparam int unsigned RST_MASK_A_BIT = 10;
  localparam int unsigned PREWARN_LSB = 11;
  localparam int unsigned WDOG_EN_BIT = 14;
  localparam logic [15:0] EXT_WORD_RST = 16'h0000;

  // Monitor selector codes
  localparam logic [3:0] SEL_CONV_A = 4'h0;
  localparam logic [3:0] SEL_CONV_B = 4'h1;
  localparam logic [3:0] SEL_CONV_C = 4'h2;
  localparam logic [3:0] SEL_OVER = 4'h4;
  localparam logic [3:0] SEL_UNDER = 4'h5;
  localparam logic [3:0] SEL_MOTOR = 4'h6;
  localparam logic [3:0] SEL_THERM = 4'h7;
  localparam logic [3:0] SEL_REV0 = 4'h8;
  localparam logic [3:0] SEL_REV1 = 4'h9;
  localparam logic [3:0] SEL_REV2 = 4'hA;
  localparam logic [3:0] SEL_VENDOR = 4'hB;

  // Thermal pre-warning codes
  localparam logic [1:0] PREWARN_ANALOG = 2'h3;

  // Oscillator ratio window, motor edges per converter period
  localparam logic [5:0] RATIO_LOW = 6'h02;
  localparam logic [5:0] RATIO_HIGH = 6'h20;

  // Dead-zone filter and watchdog timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned DEADZONE_NS = 400;
  localparam logic [7:0] DEADZONE_CYC =
    8'((DEADZONE_NS * CLK_MHZ + 999) / 1000);
  localparam int unsigned OSC_TIMEOUT_US = 100;
  localparam int unsigned OSC_TIMEOUT_CYC_DEF = OSC_TIMEOUT_US * CLK_MHZ;

  // APB register map
  localparam logic [7:0] REG_SETUP = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [31:0] CTRL_RST = {24'h00_0000, DEADZONE_CYC};

  // Raw or filtered protection detector outputs
  typedef struct packed {
    logic [2:0] over;
    logic [2:0] under;
    logic motorOc;
    logic thermal;
  } psc_trip_t;
endpackage
`default_nettype wire

// File: src/psc_pin_sync.sv
`default_nettype none
// Two-stage synchroniser with rising-edge detect for a group of pins
module psc_pin_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous pins
  input wire logic [W-1:0] pinIn,
  // Synchronised level and one-cycle rising pulse
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);
  logic [W-1:0] meta_r; // First stage, read only by the second
  logic [W-1:0] sync_r; // Second stage
  logic [W-1:0] prev_r; // Delayed copy for edge detect

  // Elaboration-time refusal of an empty pin group
  if (W < 1) begin : gBadWidth
    $error("psc_pin_sync: W must be at least 1");
  end

  // Shift the pins through the stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~prev_r;
endmodule
`default_nettype wire

// File: src/psc_protection_shutdown_config.sv
`default_nettype none
module psc_protection_shutdown_config #(
  parameter int unsigned OSC_TIMEOUT_CYC = psc_pkg::OSC_TIMEOUT_CYC_DEF,
  parameter logic [2:0] REVISION = 3'h0, // Arbitrary value
  parameter logic VENDOR_BIT = 1'b0 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial setup pins
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic latchStrobe,
  input wire logic sleepIn,
  // Oscillators
  input wire logic motor_chop_oscillator,
  input wire logic converter_oscillator,
  // Analog detectors
  input wire psc_pkg::psc_trip_t tripRaw,
  input wire logic [2:0] thermalAbove, // Temp above THERMAL_TRIP-20, -30, -40
  // Protection results
  output logic [2:0] converterEnable,
  output logic motorShutdown,
  output logic deviceShutdown,
  output logic [1:0] thermal_prewarn_margin,
  output logic thermalAnalogMode,
  // Open-drain pins, driven low while oe is high
  output logic reset_output_pin_out,
  output logic reset_output_pin_oe,
  output logic monitor_output_out,
  output logic monitor_output_oe,
  output logic thermal_warning_output_out,
  output logic thermal_warning_output_oe
);
  localparam int unsigned TW = $bits(psc_pkg::psc_trip_t);

  // Refuse timeouts that the 24-bit counter cannot hold
  if (OSC_TIMEOUT_CYC < 2 || OSC_TIMEOUT_CYC > 32'h00FF_FFFF) begin : gBadTimeout
    $error("OSC_TIMEOUT_CYC out of range");
  end

  // Synchronised pins
  logic [3:0] serLvl, serRise;
  logic [1:0] oscLvl, oscRise;
  logic [TW-1:0] tripLvl;
  logic [2:0] thermLvl;

  psc_pin_sync #(.W(4)) uSerSync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn({sleepIn, latchStrobe, serialData, serialClock}),
    .level(serLvl),
    .rise(serRise)
  );
  psc_pin_sync #(.W(2)) uOscSync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn({converter_oscillator, motor_chop_oscillator}),
    .level(oscLvl),
    .rise(oscRise)
  );
  psc_pin_sync #(.W(TW + 3)) uTripSync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn({thermalAbove, tripRaw}),
    .level({thermLvl, tripLvl}),
    .rise()
  );

  wire sclkRise = serRise[0];
  wire dataLvl = serLvl[1];
  wire strobeRise = serRise[2];
  wire sleepLvl = serLvl[3];
  wire sleepRise = serRise[3];
  wire motorOscRise = oscRise[0];
  wire convOscRise = oscRise[1];

  // Serial shift register and extended setup word
  logic [15:0] shift_r;
  logic [15:0] extWord_r; // Extended setup word, all fields default low
  logic selValid_r; // Selector released until the next extended write

  // Strobe with sleep low loads; data high there picks the extended bank
  wire extLoad = strobeRise & ~sleepLvl & dataLvl;

  // Shift on serial clock edges, latch on strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= psc_pkg::EXT_WORD_RST;
    end else if (sclkRise) begin
      shift_r <= {shift_r[14:0], dataLvl};
    end
  end

  // Word register; sleep release clears only the selector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extWord_r <= psc_pkg::EXT_WORD_RST;
      selValid_r <= 1'b0;
    end else if (extLoad) begin
      extWord_r <= shift_r;
      selValid_r <= 1'b1;
    end else if (sleepRise) begin
      extWord_r[psc_pkg::SEL_LSB +: psc_pkg::SEL_W] <= '0;
      selValid_r <= 1'b0;
    end
  end

  // Decoded fields
  wire [3:0] selCode = extWord_r[psc_pkg::SEL_LSB +: psc_pkg::SEL_W];
  wire vsdMask = extWord_r[psc_pkg::VSD_MASK_BIT];
  wire isdMask = extWord_r[psc_pkg::ISD_MASK_BIT];
  wire tsdMask = extWord_r[psc_pkg::TSD_MASK_BIT];
  wire [2:0] rstMask = {extWord_r[psc_pkg::RST_MASK_C_BIT],
                        extWord_r[psc_pkg::RST_MASK_B_BIT],
                        extWord_r[psc_pkg::RST_MASK_A_BIT]};
  wire [1:0] prewarn = extWord_r[psc_pkg::PREWARN_LSB +: 2];
  wire wdogEn = extWord_r[psc_pkg::WDOG_EN_BIT];

  // Control register from software
  logic [31:0] ctrl_r;
  wire [7:0] deadZoneCyc = ctrl_r[7:0];

  // Dead-zone filters: a trip counts once held for the programmed time
  logic [TW-1:0] tripFilt_r;
  genvar gi;
  generate
    for (gi = 0; gi < TW; gi++) begin : gFilt
      logic [7:0] cnt_r;
      // Count while the raw trip stays high, drop at once when it falls
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_r <= 8'h00;
          tripFilt_r[gi] <= 1'b0;
        end else if (!tripLvl[gi]) begin
          cnt_r <= 8'h00;
          tripFilt_r[gi] <= 1'b0;
        end else if (cnt_r >= deadZoneCyc) begin
          tripFilt_r[gi] <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  endgenerate

  psc_pkg::psc_trip_t filt;
  assign filt = tripFilt_r;

  // Converter trips per channel, bit 0 is channel A
  wire [2:0] convTrip = (filt.over | filt.under) & {3{~vsdMask}};

  // Shutdown latches
  logic [2:0] chanOff_r; // Channel stopped by its own masked trip
  logic globalOff_r; // Unmasked converter trip: reset and all off
  logic devOff_r; // Thermal or oscillator fault
  logic motorOff_r; // Motor overcurrent
  logic wdFault;

  // Trip flags set over the sleep release, so a live fault is never lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chanOff_r <= 3'h0;
      globalOff_r <= 1'b0;
      devOff_r <= 1'b0;
      motorOff_r <= 1'b0;
    end else begin
      chanOff_r <= (sleepRise ? 3'h0 : chanOff_r) | (convTrip & rstMask);
      globalOff_r <= (globalOff_r & ~sleepRise) | |(convTrip & ~rstMask);
      devOff_r <= (devOff_r & ~sleepRise) | (filt.thermal & ~tsdMask)
        | wdFault;
      motorOff_r <= (motorOff_r & ~sleepRise) | (filt.motorOc & ~isdMask);
    end
  end

  // Channels run unless stopped globally, individually or by device fault
  assign converterEnable = ~chanOff_r & {3{~globalOff_r & ~devOff_r}};
  assign motorShutdown = motorOff_r | devOff_r;
  assign deviceShutdown = devOff_r;
  assign reset_output_pin_out = 1'b0;
  assign reset_output_pin_oe = globalOff_r;

  // Oscillator watchdog: motor edges counted per converter period
  logic [5:0] mCnt_r;
  logic armed_r;
  logic [23:0] toCnt_r;
  wire ratioBad = (mCnt_r <= psc_pkg::RATIO_LOW) || (mCnt_r >= psc_pkg::RATIO_HIGH);
  wire timeout = (toCnt_r >= 24'(OSC_TIMEOUT_CYC)); // Converter oscillator stopped
  assign wdFault = wdogEn & ((armed_r & convOscRise & ratioBad) | timeout);

  // Count motor edges, saturating at the upper limit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mCnt_r <= 6'h00;
      armed_r <= 1'b0;
    end else if (!wdogEn) begin
      mCnt_r <= 6'h00;
      armed_r <= 1'b0;
    end else if (convOscRise) begin
      mCnt_r <= 6'h00;
      armed_r <= 1'b1; // First period after enable is only a start
    end else if (motorOscRise && mCnt_r < psc_pkg::RATIO_HIGH) begin
      mCnt_r <= mCnt_r + 6'h01;
    end
  end

  // Time since the last converter edge, in system clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toCnt_r <= 24'h00_0000;
    end else if (!wdogEn || convOscRise) begin
      toCnt_r <= 24'h00_0000;
    end else if (!timeout) begin
      toCnt_r <= toCnt_r + 24'h00_0001;
    end
  end

  // Monitor source selection
  logic monSig;
  always_comb begin
    unique case (selCode)
      psc_pkg::SEL_CONV_A: monSig = filt.over[0] | filt.under[0];
      psc_pkg::SEL_CONV_B: monSig = filt.over[1] | filt.under[1];
      psc_pkg::SEL_CONV_C: monSig = filt.over[2] | filt.under[2];
      psc_pkg::SEL_OVER: monSig = |filt.over;
      psc_pkg::SEL_UNDER: monSig = |filt.under;
      psc_pkg::SEL_MOTOR: monSig = filt.motorOc;
      psc_pkg::SEL_THERM: monSig = filt.thermal;
      psc_pkg::SEL_REV0: monSig = REVISION[0];
      psc_pkg::SEL_REV1: monSig = REVISION[1];
      psc_pkg::SEL_REV2: monSig = REVISION[2];
      psc_pkg::SEL_VENDOR: monSig = VENDOR_BIT;
      default: monSig = 1'b0; // Unused codes stay released
    endcase
  end

  // Registered monitor and thermal warning pins
  logic monOe_r, thOe_r;
  logic thSel;
  always_comb begin
    unique case (prewarn)
      2'h0: thSel = thermLvl[0];
      2'h1: thSel = thermLvl[1];
      2'h2: thSel = thermLvl[2];
      default: thSel = 1'b0; // Analog: digital driver released
    endcase
  end

  // Pull the pins low while the chosen condition holds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monOe_r <= 1'b0;
      thOe_r <= 1'b0;
    end else begin
      monOe_r <= selValid_r & monSig;
      thOe_r <= thSel;
    end
  end

  assign monitor_output_out = 1'b0;
  assign monitor_output_oe = monOe_r;
  assign thermal_warning_output_out = 1'b0;
  assign thermal_warning_output_oe = thOe_r;
  assign thermal_prewarn_margin = prewarn;
  assign thermalAnalogMode = (prewarn == psc_pkg::PREWARN_ANALOG);

  // APB decode
  wire setupPh = psel & ~penable;
  wire accessWr = psel & penable & pwrite;
  wire hitSetup = (paddr == psc_pkg::REG_SETUP);
  wire hitStatus = (paddr == psc_pkg::REG_STATUS);
  wire hitCtrl = (paddr == psc_pkg::REG_CTRL);
  wire badAddr = ~(hitSetup | hitStatus | hitCtrl) | (pwrite & ~hitCtrl);
  wire [31:0] statusWord = {8'h00, wdogEn, armed_r, devOff_r, motorOff_r,
                            globalOff_r, chanOff_r, 8'h00, tripFilt_r};
  wire [31:0] rdMux = hitSetup ? {16'h0000, extWord_r} :
                      hitStatus ? statusWord :
                      hitCtrl ? ctrl_r : 32'h0000_0000;

  // Read data captured in the setup phase, errors likewise
  logic errR;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      errR <= 1'b0;
    end else if (setupPh) begin
      prdata <= pwrite ? 32'h0000_0000 : rdMux;
      errR <= badAddr;
    end
  end

  // Control register write, only the dead-zone field is kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= psc_pkg::CTRL_RST;
    end else if (accessWr && hitCtrl) begin
      ctrl_r <= {24'h00_0000, pwdata[7:0]};
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & errR;
endmodule
`default_nettype wire

// File: verif/psc_checker.sv
`default_nettype none
// Watches the protection outputs of the shutdown configuration block
module psc_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins seen from outside
  input wire logic sleepIn,
  input wire logic [2:0] thermalAbove,
  // Protection results
  input wire logic [2:0] converterEnable,
  input wire logic motorShutdown,
  input wire logic deviceShutdown,
  input wire logic [1:0] thermal_prewarn_margin,
  input wire logic thermalAnalogMode,
  input wire logic reset_output_pin_oe,
  input wire logic monitor_output_oe,
  input wire logic thermal_warning_output_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // One domain only, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_WARN_MID_MARGIN: assert property (
    $rose(thermal_warning_output_oe) && thermal_prewarn_margin == 2'b01
    |-> $past(thermalAbove[1], 3))
    else $error("warning raised below the middle margin");
  // The flag leads the warning register by a cycle, hence the past term
  AST_ANALOG_NO_WARN: assert property (
    thermalAnalogMode && $past(thermalAnalogMode) |-> !thermal_warning_output_oe)
    else $error("warning pin pulled in analog mode");
  AST_WARN_MARGIN: assert property (
    $rose(thermal_warning_output_oe) && thermal_prewarn_margin == 2'b00
    |-> $past(thermalAbove[0], 3))
    else $error("warning raised below the smallest margin");
  AST_GLOBAL_OFF: assert property (
    reset_output_pin_oe |-> converterEnable == 3'b000)
    else $error("reset pin low while a channel still runs");
  AST_SLEEP_RELEASE: assert property (
    $rose(sleepIn) |-> ##[2:8] !monitor_output_oe)
    else $error("monitor pin not released after sleep rise");
  AST_DEV_CLEAR: assert property (
    $fell(deviceShutdown) |-> sleepIn)
    else $error("device shutdown cleared without sleep");
  AST_MOTOR_CLEAR: assert property (
    $fell(motorShutdown) |-> sleepIn)
    else $error("motor shutdown cleared without sleep");
  AST_CHAN_RESTART: assert property (
    $rose(converterEnable[0]) |-> sleepIn)
    else $error("channel restarted without sleep");
endmodule
`default_nettype wire

// File: verif/psc_host_model.sv
`default_nettype none
// Host controller that shifts setup words into the device
module psc_host_model (
  // Serial pins toward the device
  output logic serialClock,
  output logic serialData,
  output logic latchStrobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock stands low outside frames
  initial begin
    serialClock = 1'b0;
    serialData = 1'b0;
    latchStrobe = 1'b0;
  end
  // Data moves on the falling half so it is steady around every rise
  task automatic load(input logic [15:0] w, input logic bank);
    for (int i = 15; i >= 0; i--) begin
      serialData = w[i];
      #62.5 serialClock = 1'b1;
      #62.5 serialClock = 1'b0;
    end
    #62.5 serialData = bank;
    #62.5 latchStrobe = 1'b1;
    #62.5 latchStrobe = 1'b0;
    // Released line: show the inverse so no stale level looks valid
    serialData = !bank;
  endtask
endmodule
`default_nettype wire

// File: verif/psc_protection_shutdown_config_tb_top.sv
`default_nettype none
module psc_protection_shutdown_config_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // Stimulus and results
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sleepIn = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, mOsc = 0, cOsc = 0;
  psc_pkg::psc_trip_t tripRaw = '0;
  logic [2:0] thermalAbove = 3'b000, converterEnable, sd;
  logic [1:0] thermal_prewarn_margin;
  logic motorShutdown, deviceShutdown, thermalAnalogMode;
  logic reset_output_pin_out, reset_output_pin_oe, monitor_output_out, monitor_output_oe;
  logic thermal_warning_output_out, thermal_warning_output_oe;
  wire logic serialClock, serialData, latchStrobe;
  int fails = 0, nCompared = 0, mHalf = 2, cHalf = 40, mCnt = 0, cCnt = 0;

  always #2 clk = ~clk;
  // Oscillators; scenarios move the converter half period to break the ratio
  always @(posedge clk) begin
    mCnt <= (mCnt + 1 >= mHalf) ? 0 : mCnt + 1;
    cCnt <= (cCnt + 1 >= cHalf) ? 0 : cCnt + 1;
    if (mCnt + 1 >= mHalf) mOsc <= ~mOsc;
    if (cCnt + 1 >= cHalf) cOsc <= ~cOsc;
  end

  // Small timeout so the watchdog stays short in simulation
  psc_protection_shutdown_config #(.OSC_TIMEOUT_CYC(200), .REVISION(3'h5), .VENDOR_BIT(1'b1))
    i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .serialClock, .serialData, .latchStrobe, .sleepIn, .motor_chop_oscillator(mOsc),
    .converter_oscillator(cOsc), .tripRaw, .thermalAbove, .converterEnable, .motorShutdown,
    .deviceShutdown, .thermal_prewarn_margin, .thermalAnalogMode, .reset_output_pin_out,
    .reset_output_pin_oe, .monitor_output_out, .monitor_output_oe,
    .thermal_warning_output_out, .thermal_warning_output_oe);
  psc_host_model i_host (.serialClock, .serialData, .latchStrobe);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 20);
    if (!pready) begin
      fails++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Trips are dropped first so the latches can really clear
  task automatic sleepPulse();
    wt(8);
    sleepIn <= 1;
    wt(8);
    sleepIn <= 0;
    wt(8);
  endtask
  // Loads happen only while sleep is low
  task automatic ld(input logic [15:0] w);
    i_host.load(w, 1'b1);
    wt(6);
  endtask

  task automatic tRegs();
    apb(0, psc_pkg::REG_SETUP, 0);
    chk("setup default", rd, 0);
    apb(0, psc_pkg::REG_CTRL, 0);
    chk("ctrl default", rd, psc_pkg::CTRL_RST);
    apb(1, psc_pkg::REG_SETUP, 32'hFFFF_FFFF);
    chk("ro write", err, 1);
    apb(0, 8'h0C, 0);
    chk("unmapped data", rd, 0);
    chk("unmapped err", err, 1);
    // Open-drain pins only ever pull low
    sd = {reset_output_pin_out, monitor_output_out, thermal_warning_output_out};
    chk("od levels", sd, 0);
    apb(1, psc_pkg::REG_CTRL, 32'h0000_0008);
    ld(16'h0B57);
    apb(0, psc_pkg::REG_SETUP, 0);
    chk("ext load", rd, 32'h0000_0B57);
    i_host.load(16'h1234, 1'b0);
    wt(1);
    sleepIn <= 1;
    i_host.load(16'h00F0, 1'b1);
    wt(1);
    sleepIn <= 0;
    apb(0, psc_pkg::REG_SETUP, 0);
    // Sleep rise clears the selector field, the rest of the word stays
    chk("ignored loads", rd, 32'h0000_0B50);
  endtask
  task automatic tMon();
    logic [7:0] tr[16] = '{8'h04, 8'h40, 8'h10, 8'hFF, 8'h80, 8'h08, 8'h02, 8'h01,
      8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic [15:0] ex = 16'h0DF7;
    for (int i = 0; i < 16; i++) begin
      ld(16'(i));
      tripRaw <= tr[i];
      wt(24);
      chk("monitor", monitor_output_oe, ex[i]);
      tripRaw <= '0;
      sleepPulse();
    end
    ld(16'(psc_pkg::SEL_MOTOR));
    tripRaw <= 8'h02;
    wt(3);
    tripRaw <= '0;
    wt(24);
    chk("short pulse", monitor_output_oe, 0);
    ld(16'(psc_pkg::SEL_CONV_A));
    tripRaw <= 8'h04;
    wt(24);
    sleepIn <= 1;
    wt(12);
    chk("released", monitor_output_oe, 0);
    tripRaw <= '0;
    sleepIn <= 0;
    sleepPulse();
  endtask
  task automatic tRst();
    for (int ch = 0; ch < 3; ch++) begin
      ld(16'h0400 >> ch);
      tripRaw <= 8'h20 << ch;
      wt(24);
      chk("masked", {reset_output_pin_oe, converterEnable}, {1'b0, ~(3'b001 << ch)});
      tripRaw <= '0;
      sleepPulse();
      chk("restart", converterEnable, 3'b111);
    end
    ld(16'h0000);
    tripRaw <= 8'h40;
    wt(24);
    chk("global off", {reset_output_pin_oe, converterEnable}, 4'b1000);
    tripRaw <= '0;
    sleepPulse();
  endtask
  task automatic tMask();
    logic [7:0] tr[3] = '{8'h01, 8'h02, 8'h20};
    for (int j = 0; j < 6; j++) begin
      ld((j % 2) ? 16'h0080 >> (j / 2) : 16'h0000);
      tripRaw <= tr[j / 2];
      wt(24);
      sd = {reset_output_pin_oe, motorShutdown, deviceShutdown};
      chk("sd mask", sd[j / 2], j % 2 == 0);
      tripRaw <= '0;
      sleepPulse();
    end
  endtask
  // Analog mode is entered here only as a test
  task automatic tWarn();
    for (int m = 0; m < 4; m++) begin
      ld(16'(m) << 11);
      thermalAbove <= 3'b111 << (m + 1);
      wt(8);
      chk("warn cool", thermal_warning_output_oe, 0);
      thermalAbove <= 3'b111 << m;
      wt(8);
      chk("warn hot", {thermalAnalogMode, thermal_prewarn_margin, thermal_warning_output_oe},
        {m == 3, 2'(m), m < 3});
    end
    thermalAbove <= 3'b000;
  endtask
  task automatic tWdog();
    cHalf <= 80;
    wt(1000);
    chk("wdog idle", deviceShutdown, 0);
    ld(16'h4000);
    wt(1000);
    chk("ratio high", deviceShutdown, 1);
    cHalf <= 40;
    wt(200);
    sleepPulse();
    wt(600);
    chk("ratio ok", deviceShutdown, 0);
    cHalf <= 2;
    wt(600);
    chk("ratio low", deviceShutdown, 1);
    cHalf <= 40;
    wt(200);
    sleepPulse();
  endtask

  initial begin
    wt(2);
    rst_n <= 1;
    wt(4);
    tRegs();
    tMon();
    tRst();
    tMask();
    tWarn();
    tWdog();
    end_of_test();
  end
  initial begin
    wt(90000);
    fails++;
    end_of_test();
  end
endmodule

bind psc_protection_shutdown_config psc_checker i_chk (.clk, .rst_n, .sleepIn, .thermalAbove,
  .converterEnable, .motorShutdown, .deviceShutdown, .thermal_prewarn_margin,
  .thermalAnalogMode, .reset_output_pin_oe, .monitor_output_oe, .thermal_warning_output_oe);
`default_nettype wire
